// ### clp_clock_power_asserts.sv
// Port-level checker for the clock and low-power control block.
`timescale 1ns/1ps
`default_nettype none
module clp_clock_power_asserts #(
	parameter int MON_TIMEOUT_CYC = clp_pkg::MON_TIMEOUT_CYC
) (
	input wire logic ref_clk_in, // core clock
	input wire logic ce_in, // clock enable
	input wire logic rst_b_in, // external reset, active low
	input wire logic core_low_in, // core supply low
	input wire logic ana_low_in, // analogue supply low
	input wire logic avs_waitrequest_out, // bus wait
	input wire logic cpu_sleep_in, // sleep request
	input wire logic irq_pending_in, // interrupt pending
	input wire logic event_in, // wake event
	input wire logic independent_watchdog_reset_in, // watchdog wake
	input wire logic periph_wake_in, // peripheral wake
	input wire logic rtc_event_in, // clock event wake
	input wire logic sys_rst_b_out, // system reset, active low
	input wire logic cpu_clk_en_out, // processor gate
	input wire logic sel_int_out, // internal gate
	input wire logic sel_ext_out, // crystal gate
	input wire logic external_fast_crystal_en_out, // crystal enable
	input wire logic internal_fast_rc_oscillator_en_out, // fast RC enable
	input wire logic external_slow_crystal_en_out, // slow crystal enable
	input wire logic internal_slow_clock_en_out, // slow RC enable
	input wire logic reg_en_out, // regulator enable
	input wire logic reg_lp_out // regulator low power
);
	wire fast_on = internal_fast_rc_oscillator_en_out;
	wire deep_wake = independent_watchdog_reset_in || periph_wake_in || rtc_event_in;
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!sys_rst_b_out);
	// Both gates stay low for two cycles so no shortened pulse reaches the core.
	sequence s_gap;
		(!sel_int_out && !sel_ext_out) [*2];
	endsequence
	a_sel_exclusive: assert property (!(sel_int_out && sel_ext_out))
		else $error("both source gates high");
	a_gap_to_int: assert property ($fell(sel_ext_out) |-> s_gap ##1 sel_int_out)
		else $error("bad switch back to internal source");
	a_gap_to_ext: assert property ($rose(sel_ext_out) |->
		!$past(sel_int_out) && !$past(sel_int_out, 2) && $past(sel_int_out, 3))
		else $error("bad switch to crystal");
	a_sleep_entry: assert property (ce_in && cpu_sleep_in && cpu_clk_en_out && !irq_pending_in
		&& !event_in |=> !cpu_clk_en_out) else $error("sleep not entered");
	a_sleep_wake: assert property (ce_in && fast_on && !cpu_clk_en_out
		&& (irq_pending_in || event_in) |=> cpu_clk_en_out) else $error("sleep wake missed");
	a_deep_off: assert property ($fell(fast_on) |-> !external_fast_crystal_en_out
		&& !cpu_clk_en_out && $stable(internal_slow_clock_en_out)
		&& $stable(external_slow_crystal_en_out)) else $error("deep entry wrong");
	a_deep_wake: assert property (!fast_on && deep_wake |-> ##[1:4] cpu_clk_en_out)
		else $error("deep wake missed");
	a_reg_mode: assert property (reg_en_out && (reg_lp_out == !cpu_clk_en_out))
		else $error("regulator mode wrong");
	a_supply_rst: assert property (disable iff (!rst_b_in)
		core_low_in || ana_low_in |-> !sys_rst_b_out) else $error("supply reset missed");
	a_rst_state: assert property (disable iff (!rst_b_in) $rose(sys_rst_b_out) |->
		sel_int_out && !sel_ext_out && cpu_clk_en_out && fast_on) else $error("bad reset state");
	a_wait_pulse: assert property (ce_in && !avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low too long");
endmodule
bind clp_clock_power_top clp_clock_power_asserts #(.MON_TIMEOUT_CYC(MON_TIMEOUT_CYC))
	i_clp_clock_power_asserts (.ref_clk_in, .ce_in, .rst_b_in, .core_low_in, .ana_low_in,
	.avs_waitrequest_out, .cpu_sleep_in, .irq_pending_in, .event_in,
	.independent_watchdog_reset_in, .periph_wake_in, .rtc_event_in, .sys_rst_b_out,
	.cpu_clk_en_out, .sel_int_out, .sel_ext_out, .external_fast_crystal_en_out,
	.internal_fast_rc_oscillator_en_out, .external_slow_crystal_en_out,
	.internal_slow_clock_en_out, .reg_en_out, .reg_lp_out);
`default_nettype wire

// ### clp_clock_power_top.sv
// Core clock selection and low-power mode control with register access.
`timescale 1ns/1ps
`default_nettype none
module clp_clock_power_top #(
	parameter int MON_TIMEOUT_CYC = clp_pkg::MON_TIMEOUT_CYC
) (
	input wire logic ref_clk_in, // core clock, 100 MHz
	input wire logic rst_b_in, // external reset, active low
	input wire logic ce_in, // clock enable, freezes all state except the reset synchroniser
	input wire logic core_low_in, // core supply below threshold
	input wire logic ana_low_in, // analogue supply below threshold
	input wire logic [clp_pkg::ADDR_W-1:0] avs_address_in, // byte address
	input wire logic avs_read_in, // read request
	input wire logic avs_write_in, // write request
	input wire logic [clp_pkg::DATA_W-1:0] avs_writedata_in, // write data
	output logic [clp_pkg::DATA_W-1:0] avs_readdata_out, // read data
	output logic avs_waitrequest_out, // slave not ready
	input wire logic ext_clk_in, // crystal clock pin
	input wire logic cpu_sleep_in, // processor asks to sleep, pulse
	input wire logic irq_pending_in, // any interrupt pending
	input wire logic event_in, // wake event pulse
	input wire logic independent_watchdog_reset_in, // watchdog reset request
	input wire logic periph_wake_in, // peripheral wake interrupt
	input wire logic rtc_event_in, // real-time clock event
	output logic sys_rst_b_out, // system reset, active low
	output logic cpu_clk_en_out, // processor clock gate
	output logic sel_int_out, // internal source gate
	output logic sel_ext_out, // crystal source gate
	output logic external_fast_crystal_en_out, // crystal oscillator enable
	output logic internal_fast_rc_oscillator_en_out, // fast RC enable
	output logic external_slow_crystal_en_out, // slow crystal enable
	output logic internal_slow_clock_en_out, // slow RC enable
	output logic reg_en_out, // regulator enable
	output logic reg_lp_out, // regulator low-power mode
	output logic ahb_ce_out, // AHB domain clock enable pulse
	output logic apb_ce_out, // APB domain clock enable pulse
	output logic irq_out // interrupt, level
);
	logic [1:0] rst_sync_q;
	logic rst_b;
	logic waitreq_q;
	logic [clp_pkg::DATA_W-1:0] rdata_q;
	logic [clp_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
	logic [clp_pkg::PRESC_W-1:0] ahb_div_q, apb_div_q;
	logic [clp_pkg::PRESC_W-1:0] ahb_cnt_q, apb_cnt_q;
	logic [clp_pkg::IRQ_W-1:0] istat_q, istat_d, imask_q;
	clp_pkg::clp_sw_t sw_q, sw_d;
	clp_pkg::clp_pm_t pm_q, pm_d;
	logic [1:0] gap_q, gap_d;
	logic ahb_ce_q, apb_ce_q, irq_q, cpu_en_q, reg_lp_q;
	logic sel_int_q, sel_ext_q, fast_rc_q;
	clp_mon_if mon_link();

	// Supply monitors act as asynchronous reset sources; release is synchronised.
	wire por_b = rst_b_in & ~core_low_in & ~ana_low_in;

	always_ff @(posedge ref_clk_in or negedge por_b) begin
		if (!por_b) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_b = rst_sync_q[1];

	clp_ext_monitor #(
		.TIMEOUT_CYC(MON_TIMEOUT_CYC)
	) u_mon (
		.clk_in(ref_clk_in),
		.rst_b_in(rst_b),
		.ce_in(ce_in),
		.ext_clk_in(ext_clk_in),
		.mon(mon_link.mon)
	);
	assign mon_link.mon_en = ctrl_q[clp_pkg::CTRL_XTAL_EN];

	// Bus decode: each request is answered one cycle after it is seen.
	wire req = avs_read_in | avs_write_in;
	wire acc = req & ~waitreq_q;
	wire wr_ok = avs_write_in & ~waitreq_q;
	wire hit_ctrl = avs_address_in == clp_pkg::OFF_CTRL;
	wire hit_presc = avs_address_in == clp_pkg::OFF_PRESC;
	wire hit_status = avs_address_in == clp_pkg::OFF_STATUS;
	wire hit_istat = avs_address_in == clp_pkg::OFF_INT_STAT;
	wire hit_imask = avs_address_in == clp_pkg::OFF_INT_MASK;
	wire [clp_pkg::DATA_W-1:0] wd = avs_writedata_in;

	wire [clp_pkg::DATA_W-1:0] status_word = {16'h0000, clp_pkg::FAST_RC_DIV,
		3'h0, reg_lp_q, pm_q, mon_link.ext_running, sw_q == clp_pkg::SW_EXT};
	wire [clp_pkg::DATA_W-1:0] presc_word = {24'h000000, apb_div_q, ahb_div_q};
	logic [clp_pkg::DATA_W-1:0] rd_mux;
	always_comb begin
		if (hit_ctrl) begin
			rd_mux = {27'h0000000, ctrl_q};
		end else if (hit_presc) begin
			rd_mux = presc_word;
		end else if (hit_status) begin
			rd_mux = status_word;
		end else if (hit_istat) begin
			rd_mux = {30'h00000000, istat_q};
		end else if (hit_imask) begin
			rd_mux = {30'h00000000, imask_q};
		end else begin
			rd_mux = '0;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			waitreq_q <= 1'b1;
			rdata_q <= '0;
		end else if (ce_in) begin
			waitreq_q <= ~(req & waitreq_q);
			if (avs_read_in & waitreq_q) begin
				rdata_q <= rd_mux;
			end
		end
	end

	// Power mode sequencing.
	wire deep_wake = independent_watchdog_reset_in | periph_wake_in | rtc_event_in;
	wire deep_entry = (pm_q == clp_pkg::PM_RUN) & cpu_sleep_in
		& ctrl_q[clp_pkg::CTRL_DEEP_SEL];
	always_comb begin
		pm_d = pm_q;
		case (pm_q)
			clp_pkg::PM_RUN: begin
				if (cpu_sleep_in) begin
					pm_d = ctrl_q[clp_pkg::CTRL_DEEP_SEL] ? clp_pkg::PM_DEEP : clp_pkg::PM_SLEEP;
				end
			end
			clp_pkg::PM_SLEEP: begin
				if (irq_pending_in | event_in) begin
					pm_d = clp_pkg::PM_RUN;
				end
			end
			clp_pkg::PM_DEEP: begin
				if (deep_wake) begin
					pm_d = clp_pkg::PM_RUN;
				end
			end
			default: begin
				pm_d = clp_pkg::PM_RUN;
			end
		endcase
	end

	// Control register: hardware clears crystal use on failure or deep entry.
	wire hw_drop_ext = mon_link.ext_fail | deep_entry;
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ok & hit_ctrl) begin
			ctrl_d = wd[clp_pkg::CTRL_W-1:0];
		end
		if (hw_drop_ext) begin
			ctrl_d[clp_pkg::CTRL_SEL_EXT] = 1'b0;
		end
		if (deep_entry) begin
			ctrl_d[clp_pkg::CTRL_XTAL_EN] = 1'b0;
		end
	end

	// Source switch: both gates are dropped for a gap before the new one opens.
	wire want_ext = ctrl_q[clp_pkg::CTRL_SEL_EXT] & ctrl_q[clp_pkg::CTRL_XTAL_EN]
		& mon_link.ext_running & (pm_q != clp_pkg::PM_DEEP);
	wire gap_done = gap_q == clp_pkg::SW_GAP_CYC - 2'h1;
	always_comb begin
		sw_d = sw_q;
		gap_d = 2'h0;
		case (sw_q)
			clp_pkg::SW_INT: begin
				if (want_ext) begin
					sw_d = clp_pkg::SW_BRK_EXT;
				end
			end
			clp_pkg::SW_BRK_EXT: begin
				gap_d = gap_q + 2'h1;
				if (!want_ext) begin
					sw_d = clp_pkg::SW_BRK_INT;
					gap_d = 2'h0;
				end else if (gap_done) begin
					sw_d = clp_pkg::SW_EXT;
				end
			end
			clp_pkg::SW_EXT: begin
				if (mon_link.ext_fail || !want_ext) begin
					sw_d = clp_pkg::SW_BRK_INT;
				end
			end
			clp_pkg::SW_BRK_INT: begin
				gap_d = gap_q + 2'h1;
				if (gap_done) begin
					sw_d = clp_pkg::SW_INT;
				end
			end
			default: begin
				sw_d = clp_pkg::SW_INT;
			end
		endcase
	end

	// Interrupt flags: a new event wins over a write-one clear in the same cycle.
	wire [clp_pkg::IRQ_W-1:0] ev = {(pm_q == clp_pkg::PM_DEEP) & deep_wake,
		mon_link.ext_fail};
	wire [clp_pkg::IRQ_W-1:0] clr = (wr_ok & hit_istat) ? wd[clp_pkg::IRQ_W-1:0] : '0;
	assign istat_d = (istat_q & ~clr) | ev;

	always_ff @(posedge ref_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q <= clp_pkg::CTRL_RST;
			ahb_div_q <= clp_pkg::PRESC_AHB_RST;
			apb_div_q <= clp_pkg::PRESC_APB_RST;
			istat_q <= '0;
			imask_q <= '0;
		end else if (ce_in) begin
			ctrl_q <= ctrl_d;
			istat_q <= istat_d;
			if (wr_ok & hit_presc) begin
				ahb_div_q <= wd[clp_pkg::PRESC_AHB_LSB +: clp_pkg::PRESC_W];
				apb_div_q <= wd[clp_pkg::PRESC_APB_LSB +: clp_pkg::PRESC_W];
			end
			if (wr_ok & hit_imask) begin
				imask_q <= wd[clp_pkg::IRQ_W-1:0];
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			sw_q <= clp_pkg::SW_INT;
			gap_q <= 2'h0;
			pm_q <= clp_pkg::PM_RUN;
		end else if (ce_in) begin
			sw_q <= sw_d;
			gap_q <= gap_d;
			pm_q <= pm_d;
		end
	end

	// Bus domain prescalers; APB ticks are taken from AHB ticks.
	wire ahb_wrap = ahb_cnt_q == ahb_div_q;
	wire apb_wrap = apb_cnt_q == apb_div_q;
	always_ff @(posedge ref_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			ahb_cnt_q <= '0;
			apb_cnt_q <= '0;
			ahb_ce_q <= 1'b0;
			apb_ce_q <= 1'b0;
		end else if (ce_in) begin
			ahb_cnt_q <= ahb_wrap ? '0 : ahb_cnt_q + 4'h1;
			ahb_ce_q <= ahb_wrap;
			apb_ce_q <= ahb_wrap & apb_wrap;
			if (ahb_wrap) begin
				apb_cnt_q <= apb_wrap ? '0 : apb_cnt_q + 4'h1;
			end
		end
	end

	// Registered outputs.
	always_ff @(posedge ref_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			cpu_en_q <= 1'b1;
			reg_lp_q <= 1'b0;
			sel_int_q <= 1'b1;
			sel_ext_q <= 1'b0;
			fast_rc_q <= 1'b1;
			irq_q <= 1'b0;
		end else if (ce_in) begin
			cpu_en_q <= pm_d == clp_pkg::PM_RUN;
			reg_lp_q <= pm_d != clp_pkg::PM_RUN;
			sel_int_q <= sw_d == clp_pkg::SW_INT;
			sel_ext_q <= sw_d == clp_pkg::SW_EXT;
			fast_rc_q <= pm_d != clp_pkg::PM_DEEP;
			irq_q <= |(istat_d & imask_q);
		end
	end

	// The reset copy and slow-source bits already come from flip-flops.
	assign sys_rst_b_out = rst_b;
	assign avs_readdata_out = rdata_q;
	assign avs_waitrequest_out = waitreq_q;
	assign cpu_clk_en_out = cpu_en_q;
	assign sel_int_out = sel_int_q;
	assign sel_ext_out = sel_ext_q;
	assign external_fast_crystal_en_out = ctrl_q[clp_pkg::CTRL_XTAL_EN];
	assign internal_fast_rc_oscillator_en_out = fast_rc_q;
	assign external_slow_crystal_en_out = ctrl_q[clp_pkg::CTRL_SLOW_XTAL_EN];
	assign internal_slow_clock_en_out = ctrl_q[clp_pkg::CTRL_SLOW_RC_EN];
	assign reg_en_out = rst_b;
	assign reg_lp_out = reg_lp_q;
	assign ahb_ce_out = ahb_ce_q;
	assign apb_ce_out = apb_ce_q;
	assign irq_out = irq_q;
	wire unused_acc = acc;
endmodule
`default_nettype wire

// ### clp_ext_monitor.sv
// Crystal clock failure monitor.
`timescale 1ns/1ps
`default_nettype none
module clp_ext_monitor #(
	parameter int TIMEOUT_CYC = clp_pkg::MON_TIMEOUT_CYC
) (
	input wire logic clk_in, // core clock
	input wire logic rst_b_in, // synchronised reset, active low
	input wire logic ce_in, // clock enable
	input wire logic ext_clk_in, // crystal clock pin, sampled
	clp_mon_if.mon mon // monitor link
);
	localparam int CW = $clog2(TIMEOUT_CYC + 1);
	localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT_CYC);
	logic s1_q, s2_q, s3_q;
	logic lvl_q;
	logic [CW-1:0] cnt_q;
	logic run_q, fail_q;
	// A change counts only once the last two stages agree on the new level.
	wire edge_seen = (s2_q == s3_q) && (s3_q != lvl_q);
	wire expired = mon.mon_en && !edge_seen && (cnt_q == LIMIT - CW'(1));

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			lvl_q <= 1'b0;
		end else if (ce_in) begin
			s1_q <= ext_clk_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				lvl_q <= s3_q;
			end
		end
	end

	// The count restarts on every edge; reaching the limit flags one failure only.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_q <= '0;
			run_q <= 1'b0;
			fail_q <= 1'b0;
		end else if (ce_in) begin
			fail_q <= expired && run_q;
			if (!mon.mon_en || edge_seen) begin
				cnt_q <= '0;
			end else if (cnt_q != LIMIT) begin
				cnt_q <= cnt_q + CW'(1);
			end
			if (!mon.mon_en || expired) begin
				run_q <= 1'b0;
			end else if (edge_seen) begin
				run_q <= 1'b1;
			end
		end
	end

	assign mon.ext_running = run_q;
	assign mon.ext_fail = fail_q;
endmodule
`default_nettype wire

// ### clp_mon_if.sv
// Link between the control core and the crystal failure monitor.
`timescale 1ns/1ps
`default_nettype none
interface clp_mon_if;
	logic mon_en;
	logic ext_running;
	logic ext_fail;
	modport ctrl (output mon_en, input ext_running, input ext_fail);
	modport mon (input mon_en, output ext_running, output ext_fail);
endinterface
`default_nettype wire

// ### clp_pkg.sv
// Shared constants and types for the clock and low-power control block.
package clp_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 5;
	// Register byte offsets.
	localparam logic [4:0] OFF_CTRL = 5'h00;
	localparam logic [4:0] OFF_PRESC = 5'h04;
	localparam logic [4:0] OFF_STATUS = 5'h08;
	localparam logic [4:0] OFF_INT_STAT = 5'h0c;
	localparam logic [4:0] OFF_INT_MASK = 5'h10;
	// Control register fields.
	localparam int CTRL_SEL_EXT = 0;
	localparam int CTRL_XTAL_EN = 1;
	localparam int CTRL_SLOW_XTAL_EN = 2;
	localparam int CTRL_SLOW_RC_EN = 3;
	localparam int CTRL_DEEP_SEL = 4;
	localparam int CTRL_W = 5;
	localparam logic [4:0] CTRL_RST = 5'h08;
	// Prescaler fields: divide by value plus one.
	localparam int PRESC_AHB_LSB = 0;
	localparam int PRESC_APB_LSB = 4;
	localparam int PRESC_W = 4;
	localparam logic [3:0] PRESC_AHB_RST = 4'h0;
	localparam logic [3:0] PRESC_APB_RST = 4'h0;
	// Status register fields.
	localparam int STAT_EXT_ACTIVE = 0;
	localparam int STAT_EXT_RUNNING = 1;
	localparam int STAT_MODE_LSB = 2;
	localparam int STAT_REG_LP = 4;
	localparam int STAT_DIV_LSB = 8;
	// Interrupt status and mask fields.
	localparam int IRQ_CLK_FAIL = 0;
	localparam int IRQ_DEEP_WAKE = 1;
	localparam int IRQ_W = 2;
	// Clock figures: fast RC source divided down to the default core clock.
	localparam int FAST_RC_MHZ = 96;
	localparam int DEFAULT_CORE_MHZ = 4;
	localparam logic [7:0] FAST_RC_DIV = 8'(FAST_RC_MHZ / DEFAULT_CORE_MHZ);
	localparam int MAX_DOMAIN_MHZ = 96;
	localparam int CLK_PERIOD_NS = 10;
	// Longest gap between crystal edges before it is declared failed.
	localparam int MON_TIMEOUT_NS = 1000;
	localparam int MON_TIMEOUT_CYC = (MON_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Cycles with both sources deselected during a switch.
	localparam logic [1:0] SW_GAP_CYC = 2'h2;
	typedef enum logic [1:0] {
		SW_INT = 2'b00,
		SW_BRK_EXT = 2'b01,
		SW_EXT = 2'b10,
		SW_BRK_INT = 2'b11
	} clp_sw_t;
	typedef enum logic [1:0] {
		PM_RUN = 2'b00,
		PM_SLEEP = 2'b01,
		PM_DEEP = 2'b10
	} clp_pm_t;
endpackage

// ### clp_xtal_model.sv
// Crystal oscillator stand-in that drives the crystal pin.
`timescale 1ns/1ps
`default_nettype none
module clp_xtal_model (
	input wire logic clk_in, // core clock
	input wire logic en_in, // oscillator enable from the block
	input wire logic stall_in, // bench-commanded crystal failure
	output logic xtal_out // crystal clock
);
	logic [1:0] cnt_q = 2'h0;
	always @(posedge clk_in) begin
		cnt_q <= cnt_q + 2'h1;
	end
	// A disabled or dead crystal leaves the pin low; running, it is a quarter of the core rate.
	assign xtal_out = en_in && !stall_in && cnt_q[1];
endmodule
`default_nettype wire

// ### tb_clock_and_low_power_control.sv
// Self-checking bench for the clock and low-power control block.
`timescale 1ns/1ps
`default_nettype none
module tb_clock_and_low_power_control;
	localparam int MON = 20;
	logic clk = 1'b0, rst_b = 1'b0, c_low = 1'b0, a_low = 1'b0, rd = 1'b0, wr = 1'b0;
	logic slp = 1'b0, irqp = 1'b0, evt = 1'b0, stall = 1'b0, ce = 1'b1, xtal;
	logic [2:0] wk = 3'h0;
	logic [4:0] addr = 5'h00;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic wait_r, srst_b, cpu_en, s_int, s_ext, xen, fen, sxen, sren, ren, rlp, ahb, apb, irq;
	int num_errors = 0, checks_done = 0, cyc = 0, na, np;
	always #5 clk = ~clk;
	clp_clock_power_top #(.MON_TIMEOUT_CYC(MON)) i_clp_clock_power_top (
		.ref_clk_in(clk), .rst_b_in(rst_b), .ce_in(ce), .core_low_in(c_low), .ana_low_in(a_low),
		.avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wait_r), .ext_clk_in(xtal),
		.cpu_sleep_in(slp), .irq_pending_in(irqp), .event_in(evt),
		.independent_watchdog_reset_in(wk[2]), .periph_wake_in(wk[1]), .rtc_event_in(wk[0]),
		.sys_rst_b_out(srst_b), .cpu_clk_en_out(cpu_en), .sel_int_out(s_int), .sel_ext_out(s_ext),
		.external_fast_crystal_en_out(xen), .internal_fast_rc_oscillator_en_out(fen),
		.external_slow_crystal_en_out(sxen), .internal_slow_clock_en_out(sren),
		.reg_en_out(ren), .reg_lp_out(rlp), .ahb_ce_out(ahb), .apb_ce_out(apb), .irq_out(irq));
	clp_xtal_model i_clp_xtal_model (.clk_in(clk), .en_in(xen), .stall_in(stall), .xtal_out(xtal));
	task automatic tally_and_finish;
		if (num_errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// One Avalon access; the request holds until waitrequest is sampled low.
	// Only the bench timeout ends a wait that never gets an answer.
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk);
		end while (wait_r !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic sleep_now;
		@(posedge clk);
		slp <= 1'b1;
		@(posedge clk);
		slp <= 1'b0;
		@(posedge clk);
	endtask
	task automatic count(input int n);
		na = 0;
		np = 0;
		repeat (n) begin
			@(posedge clk);
			na += int'(ahb === 1'b1);
			np += int'(apb === 1'b1);
		end
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	initial begin
		tick(4);
		rst_b <= 1'b1;
		tick(3);
		chk({s_int, s_ext, cpu_en, fen, ren, rlp, srst_b}, 7'b1011101);
		bus(0, clp_pkg::OFF_STATUS, 32'h0);
		chk(q, {16'h0, clp_pkg::FAST_RC_DIV, 8'h00});
		bus(0, clp_pkg::OFF_CTRL, 32'h0);
		chk(q, 32'(clp_pkg::CTRL_RST));
		bus(1, 5'h14, 32'hffffffff);
		bus(0, 5'h14, 32'h0);
		chk(q, 32'h0);
		bus(1, clp_pkg::OFF_STATUS, 32'hffffffff);
		bus(0, clp_pkg::OFF_STATUS, 32'h0);
		chk(q, {16'h0, clp_pkg::FAST_RC_DIV, 8'h00});
		// AHB divides by three, APB by two AHB ticks; a whole number of periods is counted.
		bus(1, clp_pkg::OFF_PRESC, 32'h00000012);
		count(60);
		chk(na, 20);
		chk(np, 10);
		bus(1, clp_pkg::OFF_CTRL, 32'h0000000a);
		q = 32'h0;
		for (int i = 0; i < 20 && q[1] !== 1'b1; i++)
			bus(0, clp_pkg::OFF_STATUS, 32'h0);
		bus(1, clp_pkg::OFF_CTRL, 32'h0000000b);
		tick(6);
		chk({s_int, s_ext}, 2'b01);
		bus(0, clp_pkg::OFF_STATUS, 32'h0);
		chk(q[1:0], 2'b11);
		stall <= 1'b1;
		tick(MON + 10);
		chk({s_int, s_ext, irq}, 3'b100);
		bus(0, clp_pkg::OFF_CTRL, 32'h0);
		chk(q[0], 1'b0);
		bus(0, clp_pkg::OFF_INT_STAT, 32'h0);
		chk(q[0], 1'b1);
		bus(1, clp_pkg::OFF_INT_MASK, 32'h1);
		tick(2);
		chk(irq, 1'b1);
		bus(1, clp_pkg::OFF_INT_STAT, 32'h1);
		tick(2);
		chk(irq, 1'b0);
		stall <= 1'b0;
		// A frozen block must ignore a sleep request.
		ce <= 1'b0;
		sleep_now();
		chk(cpu_en, 1'b1);
		ce <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			sleep_now();
			chk({cpu_en, rlp, fen}, 3'b011);
			count(12);
			chk(na, 4);
			@(posedge clk);
			evt <= (k == 0);
			irqp <= (k == 1);
			@(posedge clk);
			evt <= 1'b0;
			irqp <= 1'b0;
			@(posedge clk);
			chk({cpu_en, rlp}, 2'b10);
		end
		bus(1, clp_pkg::OFF_CTRL, 32'h0000001e);
		tick(10);
		for (int k = 0; k < 3; k++) begin
			sleep_now();
			chk({cpu_en, fen, xen, sxen, sren, rlp}, 6'b000111);
			bus(0, clp_pkg::OFF_STATUS, 32'h0);
			chk(q[3:2], 2'b10);
			@(posedge clk);
			wk <= 3'h1 << k;
			@(posedge clk);
			wk <= 3'h0;
			tick(4);
			chk({cpu_en, fen}, 2'b11);
			bus(0, clp_pkg::OFF_INT_STAT, 32'h0);
			chk(q[1], 1'b1);
			bus(1, clp_pkg::OFF_INT_STAT, 32'h2);
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			c_low <= (k == 0);
			a_low <= (k == 1);
			tick(2);
			chk(srst_b, 1'b0);
			c_low <= 1'b0;
			a_low <= 1'b0;
			tick(3);
			chk({srst_b, s_int, s_ext}, 3'b110);
			bus(0, clp_pkg::OFF_CTRL, 32'h0);
			chk(q, 32'(clp_pkg::CTRL_RST));
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
